/* File: rtl/mcp_ctrl.sv */
// motor control core: lock retry, speed select, phase modulation, standby, parameter store
`timescale 1ns/10ps
`default_nettype none
module mcp_ctrl
	import mcp_pkg::*;
#(
	parameter int unsigned LOCK_OFF_CYC = MCP_LOCK_OFF_CYC,
	parameter int unsigned RETRY_CYC    = MCP_RETRY_CYC,
	parameter int unsigned NV_PROG_CYC  = MCP_NV_PROG_CYC
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire mcp_reg_req_t reg_req,
	output logic      [7:0]   reg_rdata,
	input  wire logic [7:0]   pwm_duty_in,
	input  wire logic [7:0]   analog_level_in,
	input  wire logic [7:0]   surge_limit_in,
	input  wire logic [7:0]   accel_limit_in,
	input  wire logic [7:0]   cl_accel_limit_in,
	input  wire logic [5:0]   elec_angle,
	input  wire logic         lock_detect,
	input  wire logic         motor_running,
	input  wire logic         over_temp,
	input  wire logic         over_curr,
	output mcp_phase_t        phase_duty,
	output logic              drive_en,
	output logic [7:0]        peak_output_duty,
	output logic              standby,
	output logic [10:0]       rm_digital,
	output logic [10:0]       kt_digital
);
	// the store sequencer writes one byte a cycle inside the programming time
	if (LOCK_OFF_CYC < 1 || RETRY_CYC < 1 || NV_PROG_CYC < MCP_NV_BYTES) begin : g_bad_timing
		$error("mcp_ctrl: timing counts too small");
	end

	typedef enum logic [1:0] {LK_RUN, LK_OFF, LK_RETRY} mcp_lock_st_t;
	typedef enum logic [1:0] {NV_LOAD, NV_IDLE, NV_PROG} mcp_nv_st_t;

	logic [7:0]   speed_r, ctrl_r, key_r, nvctl_r;
	logic [7:0]   param_r [MCP_NV_BYTES];
	logic [11:0]  dirty_r;
	logic [31:0]  lk_cnt_r, nv_cnt_r;
	logic         lock_flag_r, standby_r;
	logic [2:0]   fault_r;
	mcp_lock_st_t lk_st_r;
	mcp_nv_st_t   nv_st_r;
	logic [3:0]   nv_idx_r, nv_idx_d_r;
	logic         load_v_r;

	// register port decode
	wire       wr_speed  = reg_req.wr && reg_req.addr == MCP_ADDR_SPEED;
	wire       wr_ctrl   = reg_req.wr && reg_req.addr == MCP_ADDR_CTRL;
	wire       wr_key    = reg_req.wr && reg_req.addr == MCP_ADDR_DEVCTL;
	wire       wr_nvctl  = reg_req.wr && reg_req.addr == MCP_ADDR_NVCTL;
	wire       in_param  = reg_req.addr >= MCP_ADDR_PARAM0 && reg_req.addr <= MCP_ADDR_PARAML;
	wire [3:0] param_idx = 4'(reg_req.addr - MCP_ADDR_PARAM0);
	wire       wr_param  = reg_req.wr && in_param;
	// trigger only accepted with the key already in place
	wire       nv_start  = wr_nvctl && reg_req.wdata[MCP_NV_TRIGGER]
	                       && key_r == MCP_PROG_KEY && nv_st_r == NV_IDLE;
	// busy bit survives host writes to the other control bits until the store is done
	wire       nv_done   = nv_st_r == NV_PROG && nv_cnt_r == 32'(NV_PROG_CYC - 1);
	wire       trig_nxt  = nv_start || (nvctl_r[MCP_NV_TRIGGER] && !nv_done);

	wire [7:0] status_w = (8'(over_temp) << MCP_ST_OVERTEMP)
	                      | (8'(standby_r) << MCP_ST_STANDBY)
	                      | (8'(over_curr) << MCP_ST_OVERCURR)
	                      | (8'(lock_flag_r) << MCP_ST_LOCK);
	wire [7:0] rd_mux   = reg_req.addr == MCP_ADDR_SPEED  ? speed_r :
	                      reg_req.addr == MCP_ADDR_CTRL   ? ctrl_r :
	                      reg_req.addr == MCP_ADDR_DEVCTL ? key_r :
	                      reg_req.addr == MCP_ADDR_NVCTL  ? nvctl_r :
	                      reg_req.addr == MCP_ADDR_STATUS ? status_w :
	                      reg_req.addr == MCP_ADDR_FAULT  ? {5'h00, fault_r} :
	                      in_param ? param_r[param_idx] : MCP_BYTE_ZERO;

	// read data registered; unmapped addresses read zero, port stays live in standby
	always_ff @(posedge ref_clk) begin
		if (rst) reg_rdata <= MCP_BYTE_ZERO;
		else if (reg_req.rd) reg_rdata <= rd_mux;
	end

	// control registers; trigger clears in hardware when programming ends
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			speed_r <= MCP_BYTE_ZERO;
			ctrl_r  <= MCP_BYTE_ZERO;
			key_r   <= MCP_BYTE_ZERO;
			nvctl_r <= MCP_BYTE_ZERO;
		end else begin
			if (wr_speed) speed_r <= reg_req.wdata;
			if (wr_ctrl) ctrl_r <= reg_req.wdata;
			if (wr_key) key_r <= reg_req.wdata;
			if (wr_nvctl) nvctl_r <= reg_req.wdata;
			nvctl_r[MCP_NV_TRIGGER] <= trig_nxt;
		end
	end

	// store sequencer: load after reset, then program on a keyed trigger
	wire [3:0] mem_addr = nv_idx_r;
	wire       mem_wr   = nv_st_r == NV_PROG && nv_cnt_r < 32'(MCP_NV_BYTES);
	wire [7:0] mem_rdata;

	mcp_nv_mem #(.DEPTH(MCP_NV_BYTES)) u_mcp_nv_mem (
		.ref_clk (ref_clk),
		.wr_en   (mem_wr),
		.addr    (mem_addr),
		.wdata   (param_r[nv_idx_r]),
		.rdata   (mem_rdata)
	);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			nv_st_r    <= NV_LOAD;
			nv_idx_r   <= 4'h0;
			nv_idx_d_r <= 4'h0;
			load_v_r   <= 1'b0;
			nv_cnt_r   <= 32'h0000_0000;
		end else begin
			nv_idx_d_r <= nv_idx_r;
			case (nv_st_r)
				NV_LOAD: begin
					load_v_r <= 1'b1;
					if (nv_idx_r == 4'(MCP_NV_BYTES - 1)) nv_st_r <= NV_IDLE;
					else nv_idx_r <= nv_idx_r + 4'h1;
				end
				NV_IDLE: begin
					load_v_r <= 1'b0;
					nv_idx_r <= 4'h0;
					nv_cnt_r <= 32'h0000_0000;
					if (nv_start) nv_st_r <= NV_PROG;
				end
				NV_PROG: begin
					nv_cnt_r <= nv_cnt_r + 32'h0000_0001;
					if (nv_idx_r != 4'(MCP_NV_BYTES - 1)) nv_idx_r <= nv_idx_r + 4'h1;
					if (nv_cnt_r == 32'(NV_PROG_CYC - 1)) nv_st_r <= NV_IDLE;
				end
				default: nv_st_r <= NV_IDLE;
			endcase
		end
	end

	// parameter bytes: host writes mark a byte so a late load cannot overwrite it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dirty_r <= 12'h000;
			for (int i = 0; i < MCP_NV_BYTES; i++) param_r[i] <= MCP_BYTE_ZERO;
		end else begin
			if (load_v_r && !dirty_r[nv_idx_d_r] && !wr_param)
				param_r[nv_idx_d_r] <= mem_rdata;
			if (wr_param) begin
				param_r[param_idx] <= reg_req.wdata;
				dirty_r[param_idx] <= 1'b1;
			end
		end
	end

	// parameter decode: mantissa shifted left by exponent, codes in low seven bits
	wire [7:0] rm_code = param_r[0];
	wire [7:0] kt_code = param_r[1];
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rm_digital <= 11'h000;
			kt_digital <= 11'h000;
		end else begin
			rm_digital <= 11'({7'h00, rm_code[3:0]} << rm_code[6:4]);
			kt_digital <= 11'({7'h00, kt_code[3:0]} << kt_code[6:4]);
		end
	end

	// lock protection: off window, then a retry window watching for the lock again
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lk_st_r     <= LK_RUN;
			lk_cnt_r    <= 32'h0000_0000;
			lock_flag_r <= 1'b0;
			fault_r     <= MCP_FAULT_NONE;
		end else begin
			case (lk_st_r)
				LK_RUN: begin
					lk_cnt_r <= 32'h0000_0000;
					if (lock_detect) begin
						lk_st_r     <= LK_OFF;
						lock_flag_r <= 1'b1;
						fault_r     <= MCP_FAULT_LOCK;
					end
				end
				LK_OFF: begin
					lk_cnt_r <= lk_cnt_r + 32'h0000_0001;
					if (lk_cnt_r == 32'(LOCK_OFF_CYC - 1)) begin
						lk_st_r  <= LK_RETRY;
						lk_cnt_r <= 32'h0000_0000;
					end
				end
				LK_RETRY: begin
					lk_cnt_r <= lk_cnt_r + 32'h0000_0001;
					if (lock_detect) begin
						lk_st_r  <= LK_OFF;
						lk_cnt_r <= 32'h0000_0000;
					end else if (lk_cnt_r == 32'(RETRY_CYC - 1)) begin
						lk_st_r     <= LK_RUN;
						lock_flag_r <= 1'b0;
						fault_r     <= MCP_FAULT_NONE;
					end
				end
				default: lk_st_r <= LK_RUN;
			endcase
		end
	end

	// speed source select and limiting; smallest of command and limiters wins
	wire [1:0] src     = ctrl_r[MCP_CTRL_SRC_LO +: 2];
	wire [7:0] cmd     = src == MCP_SRC_PWM    ? pwm_duty_in :
	                     src == MCP_SRC_ANALOG ? analog_level_in : speed_r;
	wire [7:0] lim_a   = cmd < surge_limit_in ? cmd : surge_limit_in;
	wire [7:0] lim_b   = lim_a < accel_limit_in ? lim_a : accel_limit_in;
	wire [7:0] peak_w  = lim_b < cl_accel_limit_in ? lim_b : cl_accel_limit_in;

	// standby: wakes only on run demand, inhibit just blocks entry
	wire run_demand = motor_running || cmd != MCP_BYTE_ZERO;
	always_ff @(posedge ref_clk) begin
		if (rst) standby_r <= 1'b0;
		else if (run_demand) standby_r <= 1'b0;
		else if (!ctrl_r[MCP_CTRL_INHIBIT]) standby_r <= 1'b1;
	end

	// sine from a quarter-wave table of 17 points
	function automatic logic signed [8:0] mcp_sin(input logic [5:0] ang);
		logic [4:0] q;
		logic [6:0] m;
		q = ang[4] ? 5'(5'h10 - {1'b0, ang[3:0]}) : {1'b0, ang[3:0]};
		case (q)
			5'h00: m = 7'd0;   5'h01: m = 7'd12;  5'h02: m = 7'd25;  5'h03: m = 7'd37;
			5'h04: m = 7'd49;  5'h05: m = 7'd60;  5'h06: m = 7'd71;  5'h07: m = 7'd81;
			5'h08: m = 7'd90;  5'h09: m = 7'd98;  5'h0A: m = 7'd106; 5'h0B: m = 7'd112;
			5'h0C: m = 7'd117; 5'h0D: m = 7'd122; 5'h0E: m = 7'd125; 5'h0F: m = 7'd126;
			default: m = 7'd127;
		endcase
		mcp_sin = ang[5] ? -$signed({2'b00, m}) : $signed({2'b00, m});
	endfunction : mcp_sin

	// subtracting the lowest phase pins it to ground and adds the third harmonic
	wire signed [8:0] sa = mcp_sin(elec_angle);
	wire signed [8:0] sb = mcp_sin(6'(elec_angle - MCP_ANG_120));
	wire signed [8:0] sc = mcp_sin(6'(elec_angle - MCP_ANG_240));
	wire signed [8:0] smin = (sa < sb) ? ((sa < sc) ? sa : sc) : ((sb < sc) ? sb : sc);
	wire [7:0] da = 8'(sa - smin);
	wire [7:0] db = 8'(sb - smin);
	wire [7:0] dc = 8'(sc - smin);

	// scale so the widest phase difference lands at the peak duty; clamp rounding
	function automatic logic [7:0] mcp_scale(input logic [7:0] d, input logic [7:0] pk);
		logic [23:0] p;
		p = (24'(d) * 24'(pk) * 24'(MCP_NORM_MUL)) >> MCP_NORM_SHIFT; // widen first, no wrap
		mcp_scale = p > 24'(pk) ? pk : p[7:0];
	endfunction : mcp_scale

	wire drive_w = lk_st_r != LK_OFF && !standby_r;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			phase_duty       <= '0;
			peak_output_duty <= MCP_BYTE_ZERO;
			drive_en         <= 1'b0;
		end else begin
			peak_output_duty <= peak_w;
			drive_en         <= drive_w;
			phase_duty.a     <= drive_w ? mcp_scale(da, peak_w) : MCP_BYTE_ZERO;
			phase_duty.b     <= drive_w ? mcp_scale(db, peak_w) : MCP_BYTE_ZERO;
			phase_duty.c     <= drive_w ? mcp_scale(dc, peak_w) : MCP_BYTE_ZERO;
		end
	end

	assign standby = standby_r;
endmodule : mcp_ctrl
`default_nettype wire

/* File: rtl/mcp_pkg.sv */
// package: register map, field layout and timing constants of the motor control block
package mcp_pkg;
	// register offsets on the serial register port
	localparam logic [7:0] MCP_ADDR_SPEED   = 8'h00;
	localparam logic [7:0] MCP_ADDR_CTRL    = 8'h01;
	localparam logic [7:0] MCP_ADDR_DEVCTL  = 8'h02;
	localparam logic [7:0] MCP_ADDR_NVCTL   = 8'h03;
	localparam logic [7:0] MCP_ADDR_STATUS  = 8'h10;
	localparam logic [7:0] MCP_ADDR_FAULT   = 8'h11;
	localparam logic [7:0] MCP_ADDR_PARAM0  = 8'h20;
	localparam logic [7:0] MCP_ADDR_PARAM1  = 8'h21;
	localparam logic [7:0] MCP_ADDR_PARAML  = 8'h2B;
	// field positions
	localparam int MCP_CTRL_SRC_LO    = 0;
	localparam int MCP_CTRL_INHIBIT   = 2;
	localparam int MCP_NV_TRIGGER     = 0;
	localparam int MCP_NV_SHADOW      = 1;
	localparam int MCP_ST_OVERTEMP    = 7;
	localparam int MCP_ST_STANDBY     = 6;
	localparam int MCP_ST_OVERCURR    = 5;
	localparam int MCP_ST_LOCK        = 4;
	// values
	localparam logic [7:0] MCP_PROG_KEY     = 8'hB6;
	localparam logic [2:0] MCP_FAULT_NONE   = 3'h0;
	localparam logic [2:0] MCP_FAULT_LOCK   = 3'h1;
	localparam logic [7:0] MCP_BYTE_ZERO    = 8'h00;
	localparam int         MCP_NV_BYTES     = 12;
	// speed command sources
	typedef enum logic [1:0] {
		MCP_SRC_PWM    = 2'h0,
		MCP_SRC_ANALOG = 2'h1,
		MCP_SRC_SERIAL = 2'h2
	} mcp_src_t;
	// timing: clock rate and printed times
	localparam int unsigned MCP_CLK_KHZ      = 200000;
	localparam int unsigned MCP_LOCK_OFF_S   = 5;
	localparam int unsigned MCP_LOCK_ENTER_MS = 300;
	localparam int unsigned MCP_NV_PROG_MS   = 24;
	localparam int unsigned MCP_LOCK_OFF_CYC = MCP_LOCK_OFF_S * MCP_CLK_KHZ * 1000;
	localparam int unsigned MCP_RETRY_CYC    = MCP_LOCK_ENTER_MS * MCP_CLK_KHZ;
	localparam int unsigned MCP_NV_PROG_CYC  = MCP_NV_PROG_MS * MCP_CLK_KHZ;
	// modulation: 120 and 240 degree offsets on a 64-step angle, scale to peak
	localparam logic [5:0]  MCP_ANG_120      = 6'h15;
	localparam logic [5:0]  MCP_ANG_240      = 6'h2B;
	localparam logic [7:0]  MCP_NORM_MUL     = 8'h95;
	localparam int          MCP_NORM_SHIFT   = 15;
	// register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mcp_reg_req_t;
	// phase duties
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
	} mcp_phase_t;
endpackage : mcp_pkg

/* File: rtl/mcp_nv_mem.sv */
// non-volatile parameter store: byte array with registered read data
`timescale 1ns/10ps
`default_nettype none
module mcp_nv_mem #(
	parameter int DEPTH = 12
) (
	input  wire logic                     ref_clk,
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] addr,
	input  wire logic [7:0]               wdata,
	output logic      [7:0]               rdata
);
	// a one-byte store leaves the address counter nothing to count
	if (DEPTH < 2) begin : g_bad_depth
		$error("mcp_nv_mem: depth too small");
	end

	// blank contents stand for an erased store; no reset, the bytes must outlive rst
	logic [7:0] mem [DEPTH] = '{default: 8'h00};

	// single port, read data always comes from a flop
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : mcp_nv_mem
`default_nettype wire

/* File: dv/mcp_ctrl_checker.sv */
// checker: port-level assertions for the motor control core
`timescale 1ns/10ps
`default_nettype none
module mcp_ctrl_checker
	import mcp_pkg::*;
#(
	parameter int unsigned LOCK_OFF_CYC = 50
) (
	input wire logic         ref_clk,
	input wire logic         rst,
	input wire mcp_reg_req_t reg_req,
	input wire logic [7:0]   reg_rdata,
	input wire logic [7:0]   surge_limit_in,
	input wire logic [7:0]   accel_limit_in,
	input wire logic [7:0]   cl_accel_limit_in,
	input wire logic         lock_detect,
	input wire logic         motor_running,
	input wire mcp_phase_t   phase_duty,
	input wire logic         drive_en,
	input wire logic [7:0]   peak_output_duty,
	input wire logic         standby,
	input wire logic [10:0]  rm_digital,
	input wire logic [10:0]  kt_digital
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// own decode, kept apart from the core's
	function automatic logic [10:0] dec(input logic [7:0] c);
		return {7'h00, c[3:0]} << c[6:4];
	endfunction : dec
	// cycles with drive off outside standby; bounds the lock-off window
	logic [15:0] off_cnt_r;
	always_ff @(posedge ref_clk) begin
		if (rst || drive_en || standby)
			off_cnt_r <= 16'h0000;
		else
			off_cnt_r <= off_cnt_r + 16'h0001;
	end
	chk_lock_stop: assert property (lock_detect && drive_en |-> ##2 !drive_en)
		else $error("drive still on after lock");
	chk_phase_off: assert property (!drive_en |-> phase_duty == '0)
		else $error("phase driven while drive off");
	chk_lock_retry: assert property (off_cnt_r <= LOCK_OFF_CYC + 4)
		else $error("drive not resumed after off window");
	chk_peak_limit: assert property ($stable(surge_limit_in) && $stable(accel_limit_in)
		&& $stable(cl_accel_limit_in) |-> peak_output_duty <= surge_limit_in
		&& peak_output_duty <= accel_limit_in && peak_output_duty <= cl_accel_limit_in)
		else $error("peak above a limiter");
	chk_flat_phase: assert property (drive_en |-> phase_duty.a == 8'h00
		|| phase_duty.b == 8'h00 || phase_duty.c == 8'h00)
		else $error("no phase held at ground");
	chk_peak_clamp: assert property ($stable(peak_output_duty) |->
		phase_duty.a <= peak_output_duty && phase_duty.b <= peak_output_duty
		&& phase_duty.c <= peak_output_duty)
		else $error("phase above peak duty");
	chk_standby_exit: assert property (standby && motor_running |=> !standby)
		else $error("standby kept with motor running");
	chk_standby_drive: assert property (standby && $past(standby) |-> !drive_en)
		else $error("drive on in standby");
	chk_standby_flag: assert property (reg_req.rd && reg_req.addr == MCP_ADDR_STATUS
		|=> reg_rdata[6] == $past(standby))
		else $error("status standby bit wrong");
	chk_rm_decode: assert property (reg_req.wr && reg_req.addr == MCP_ADDR_PARAM0
		|-> ##2 rm_digital == dec($past(reg_req.wdata, 2)))
		else $error("resistance decode wrong");
	chk_kt_decode: assert property (reg_req.wr && reg_req.addr == MCP_ADDR_PARAM1
		|-> ##2 kt_digital == dec($past(reg_req.wdata, 2)))
		else $error("velocity decode wrong");
endmodule : mcp_ctrl_checker
bind mcp_ctrl mcp_ctrl_checker #(.LOCK_OFF_CYC(LOCK_OFF_CYC)) u_mcp_ctrl_checker (
	.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.surge_limit_in(surge_limit_in), .accel_limit_in(accel_limit_in),
	.cl_accel_limit_in(cl_accel_limit_in), .lock_detect(lock_detect),
	.motor_running(motor_running), .phase_duty(phase_duty), .drive_en(drive_en),
	.peak_output_duty(peak_output_duty), .standby(standby),
	.rm_digital(rm_digital), .kt_digital(kt_digital));
`default_nettype wire

/* File: dv/mcp_host.sv */
// host model: byte requests as the serial decoder hands them to the core
`timescale 1ns/10ps
`default_nettype none
module mcp_host
	import mcp_pkg::*;
(
	input  wire logic [7:0]   reg_rdata,
	input  wire logic         ref_clk,
	output var mcp_reg_req_t  reg_req
);
	initial reg_req = '0;
	// one request cycle, then idle, so two requests never share an edge
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(posedge ref_clk);
		reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge ref_clk);
		reg_req <= '0;
		@(posedge ref_clk);
		#1 q = reg_rdata;
	endtask : xfer
	// store programming: shadow select, bytes, key, then trigger
	task automatic nv_prog(input logic [7:0] base);
		logic [7:0] q;
		xfer(1'b1, MCP_ADDR_NVCTL, 8'h02, q);
		for (int i = 0; i < MCP_NV_BYTES; i++)
			xfer(1'b1, MCP_ADDR_PARAM0 + 8'(i), base + 8'(i), q);
		xfer(1'b1, MCP_ADDR_DEVCTL, MCP_PROG_KEY, q);
		xfer(1'b1, MCP_ADDR_NVCTL, 8'h03, q);
	endtask : nv_prog
endmodule : mcp_host
`default_nettype wire

/* File: dv/test_mcp_ctrl.sv */
// testbench: register-level scenarios for the motor control core
`timescale 1ns/10ps
`default_nettype none
module test_mcp_ctrl
	import mcp_pkg::*;
;
	localparam int unsigned OFF_C = 50;
	localparam int unsigned RET_C = 20;
	logic         ref_clk = 1'b0;
	logic         rst = 1'b1;
	mcp_reg_req_t reg_req;
	logic [7:0]   reg_rdata, peak, q, pk;
	logic [7:0]   surge = 8'hFF, accel = 8'hFF, cl_lim = 8'hFF;
	logic [5:0]   angle = 6'h00;
	logic         lock = 1'b0, running = 1'b1, otemp = 1'b0, ocurr = 1'b0;
	logic         drive_en, standby;
	mcp_phase_t   phase_duty;
	logic [10:0]  rm_digital, kt_digital;
	logic [7:0]   codes [3] = '{8'h7F, 8'h03, 8'h5A};
	logic [10:0]  decs [3] = '{11'h780, 11'h003, 11'h140};
	int           n_errors = 0, n_checks = 0, n;
	initial forever #2.5 ref_clk = ~ref_clk;
	mcp_ctrl #(.LOCK_OFF_CYC(OFF_C), .RETRY_CYC(RET_C), .NV_PROG_CYC(40)) u_mcp_ctrl (
		.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.pwm_duty_in(8'h40), .analog_level_in(8'h60), .surge_limit_in(surge),
		.accel_limit_in(accel), .cl_accel_limit_in(cl_lim), .elec_angle(angle),
		.lock_detect(lock), .motor_running(running), .over_temp(otemp),
		.over_curr(ocurr), .phase_duty(phase_duty), .drive_en(drive_en),
		.peak_output_duty(peak), .standby(standby), .rm_digital(rm_digital),
		.kt_digital(kt_digital));
	mcp_host u_mcp_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
	task automatic test_done();
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic check(input logic [10:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, d);
		u_mcp_host.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, exp);
		u_mcp_host.xfer(1'b0, a, 8'h00, q);
		check(11'(q), 11'(exp));
	endtask : rd
	// settle point just after an edge, so registered outputs are final
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic do_reset();
		rst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(20);
	endtask : do_reset
	// bounded wait on drive_en; a spent bound ends the run
	task automatic wait_drive(output int c);
		c = 0;
		while (drive_en !== 1'b1) begin
			cyc(1);
			c++;
			if (c > 200) begin
				n_errors++;
				test_done();
			end
		end
	endtask : wait_drive
	// largest phase duty over one electrical turn
	task automatic sweep(output logic [7:0] m);
		m = 8'h00;
		for (int i = 0; i < 64; i++) begin
			@(posedge ref_clk) angle <= 6'(i);
			#1;
			if (phase_duty.a > m) m = phase_duty.a;
			if (phase_duty.b > m) m = phase_duty.b;
			if (phase_duty.c > m) m = phase_duty.c;
		end
	endtask : sweep
	initial begin
		do_reset();
		rd(MCP_ADDR_STATUS, 8'h00);
		rd(8'h40, 8'h00);
		wr(MCP_ADDR_SPEED, 8'h80);
		// every source code, serial twice
		for (int s = 0; s < 4; s++) begin
			wr(MCP_ADDR_CTRL, 8'(s));
			cyc(2);
			check(11'(peak), s == 0 ? 11'h040 : s == 1 ? 11'h060 : 11'h080);
		end
		// each limiter pulls the peak under the command
		@(posedge ref_clk) surge <= 8'h30;
		cyc(2);
		check(11'(peak), 11'h030);
		@(posedge ref_clk) accel <= 8'h20;
		cyc(2);
		check(11'(peak), 11'h020);
		@(posedge ref_clk) cl_lim <= 8'h10;
		cyc(2);
		check(11'(peak), 11'h010);
		@(posedge ref_clk) {surge, accel, cl_lim} <= 24'hFF_FFFF;
		wr(MCP_ADDR_SPEED, 8'hFF);
		sweep(pk);
		check(11'(pk > 8'hF0), 11'h001);
		wr(MCP_ADDR_SPEED, 8'h80);
		sweep(pk);
		check(11'(pk > 8'h78 && pk <= 8'h80), 11'h001);
		// lock while driving, released inside the off window
		@(posedge ref_clk) lock <= 1'b1;
		cyc(3);
		check(11'(drive_en), 11'h000);
		rd(MCP_ADDR_STATUS, 8'h10);
		rd(MCP_ADDR_FAULT, 8'h01);
		@(posedge ref_clk) lock <= 1'b0;
		wait_drive(n);
		check(11'(n >= 36 && n <= 46), 11'h001);
		@(posedge ref_clk) lock <= 1'b1;
		cyc(3);
		check(11'(drive_en), 11'h000);
		@(posedge ref_clk) lock <= 1'b0;
		wait_drive(n);
		cyc(RET_C + 4);
		rd(MCP_ADDR_STATUS, 8'h00);
		rd(MCP_ADDR_FAULT, 8'h00);
		// zero serial command and a stopped motor
		wr(MCP_ADDR_SPEED, 8'h00);
		@(posedge ref_clk) running <= 1'b0;
		cyc(3);
		check(11'(standby), 11'h001);
		@(posedge ref_clk) {otemp, ocurr} <= 2'h3;
		rd(MCP_ADDR_STATUS, 8'hE0);
		@(posedge ref_clk) {otemp, ocurr} <= 2'h0;
		wr(MCP_ADDR_CTRL, 8'h06);
		cyc(2);
		check(11'(standby), 11'h001);
		@(posedge ref_clk) running <= 1'b1;
		cyc(2);
		check(11'(standby), 11'h000);
		@(posedge ref_clk) running <= 1'b0;
		cyc(4);
		check(11'(standby), 11'h000);
		wr(MCP_ADDR_CTRL, 8'h02);
		cyc(2);
		check(11'(standby), 11'h001);
		for (int i = 0; i < 3; i++) begin
			wr(MCP_ADDR_PARAM0, codes[i]);
			wr(MCP_ADDR_PARAM1, codes[i]);
			cyc(1);
			check(rm_digital, decs[i]);
			check(kt_digital, decs[i]);
			rd(MCP_ADDR_PARAM0, codes[i]);
		end
		// a wrong key leaves the trigger clear
		wr(MCP_ADDR_DEVCTL, 8'hB7);
		wr(MCP_ADDR_NVCTL, 8'h01);
		rd(MCP_ADDR_NVCTL, 8'h00);
		u_mcp_host.nv_prog(8'h50);
		rd(MCP_ADDR_NVCTL, 8'h03);
		n = 0;
		do begin
			u_mcp_host.xfer(1'b0, MCP_ADDR_NVCTL, 8'h00, q);
			n++;
		end while (q[0] !== 1'b0 && n < 30);
		check(11'(n >= 10 && n <= 15), 11'h001);
		if (n >= 30)
			test_done();
		@(posedge ref_clk);
		do_reset();
		for (int i = 0; i < MCP_NV_BYTES; i++)
			rd(MCP_ADDR_PARAM0 + 8'(i), 8'h50 + 8'(i));
		wr(MCP_ADDR_PARAM1, 8'h12);
		rd(MCP_ADDR_PARAM1, 8'h12);
		test_done();
	end
endmodule : test_mcp_ctrl
`default_nettype wire
